/* File: design/lldc_consts.vh */
// Constants for the low-latency DRAM command protocol device model.
`ifndef LLDC_CONSTS_VH
`define LLDC_CONSTS_VH
// Command codes on {cs_n, we_n, ref_n}.
`define LLDC_CMD_MRS 3'b000
`define LLDC_CMD_READ 3'b011
`define LLDC_CMD_WRITE 3'b001
`define LLDC_CMD_BANK_REFRESH_CMD 3'b010
// Mode register field positions.
`define LLDC_MODE_CFG_LO 0
`define LLDC_MODE_CFG_HI 2
`define LLDC_MODE_BL_LO 3
`define LLDC_MODE_BL_HI 4
`define LLDC_MODE_DLL_BIT 7
// Reset values.
`define LLDC_MODE_RESET 10'h000
// Configuration table, read latency and row cycle in cycles.
`define LLDC_CFG1_LAT 4'h4
`define LLDC_CFG2_LAT 4'h6
`define LLDC_CFG3_LAT 4'h8
`define LLDC_CFG4_LAT 4'h3
`define LLDC_CFG5_LAT 4'h5
// Number of dummy plus valid mode-set commands that reset the logic.
`define LLDC_MRS_RESET_COUNT 2'h3
`endif

/* File: design/lldc_fifo.v */
// Small FIFO holding read data elements on their way to the data pins.
`timescale 1ns/10ps
`default_nettype none
module lldc_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	input wire flush
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	wire [AW:0] used;
	wire push;
	wire pop;

	assign used = wr_q - rd_q;
	assign in_ready = (used != DEPTH[AW:0]);
	assign out_valid = (used != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge sys_clk) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else if (flush) begin
			rd_q <= wr_q;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // lldc_fifo
`default_nettype wire

/* File: design/lldc_mem.v */
// Memory array with per-element write enable and registered read data.
`timescale 1ns/10ps
`default_nettype none
module lldc_mem #(
	parameter WIDTH = 9,
	parameter AW = 8
) (
	// Clock
	input wire sys_clk,
	// Write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	// Read port
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem_q [0:(1<<AW)-1];

	always @(posedge sys_clk) begin
		if (wr_en)
			mem_q[wr_addr] <= wr_data;
		rd_data <= mem_q[rd_addr];
	end
endmodule // lldc_mem
`default_nettype wire

/* File: design/lldc_device.v */
// Device side of the low-latency DRAM command and data protocol.
// ----------------------------------------
// Summary of operation
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "lldc_consts.vh"
module lldc_device #(
	parameter DW = 9,
	parameter AW = 8,
	parameter BANKS = 8,
	parameter BAW = 3,
	parameter ROWW = 13,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Command pins, sampled as main clock domain
	input wire cs_n,
	input wire we_n,
	input wire ref_n,
	input wire [BAW-1:0] bank_addr,
	input wire [AW-1:0] addr,
	// Write data clock and mask from the controller
	input wire write_data_clock,
	input wire write_mask,
	// Two-way data pins
	input wire [DW-1:0] dq_in,
	output reg [DW-1:0] dq_out,
	output reg dq_oe,
	// Read data clock and strobe
	output reg read_data_clock,
	output reg read_valid_strobe,
	// Status
	output reg init_done,
	output reg [ROWW-1:0] refresh_row,
	output reg [BANKS-1:0] bank_busy
);
	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire [2:0] cmd;
	wire is_read;
	wire is_write;
	wire is_bank_refresh_cmd;
	wire is_mrs;
	assign cmd = {cs_n, we_n, ref_n};
	// Commands come from logic on this clock, so no synchroniser here.
	assign is_read = (cmd == `LLDC_CMD_READ);
	assign is_write = (cmd == `LLDC_CMD_WRITE);
	assign is_bank_refresh_cmd = (cmd == `LLDC_CMD_BANK_REFRESH_CMD);
	assign is_mrs = (cmd == `LLDC_CMD_MRS);

	// ----------------------------------------
	// Mode register and initialisation
	// ----------------------------------------
	reg [9:0] mode_q;
	reg [1:0] mrs_cnt_q;
	reg [BANKS-1:0] init_ref_q;
	reg [3:0] rl;
	reg [2:0] blen;
	always @* begin
		case (mode_q[`LLDC_MODE_CFG_HI:`LLDC_MODE_CFG_LO])
		3'h1: rl = `LLDC_CFG2_LAT;
		3'h2: rl = `LLDC_CFG3_LAT;
		3'h3: rl = `LLDC_CFG4_LAT;
		3'h4: rl = `LLDC_CFG5_LAT;
		default: rl = `LLDC_CFG1_LAT;
		endcase
		case (mode_q[`LLDC_MODE_BL_HI:`LLDC_MODE_BL_LO])
		2'h1: blen = 3'h4;
		2'h2: blen = 3'h7;
		default: blen = 3'h2;
		endcase
	end
	wire [3:0] wl;
	assign wl = rl + 4'h1;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `LLDC_MODE_RESET;
			mrs_cnt_q <= 2'h0;
			init_ref_q <= {BANKS{1'b0}};
			init_done <= 1'b0;
		end else begin
			if (is_mrs) begin
				mode_q <= addr[7:0] == 8'h00 ? mode_q : {2'h0, addr[7:0]};
				if (mrs_cnt_q != `LLDC_MRS_RESET_COUNT)
					mrs_cnt_q <= mrs_cnt_q + 2'h1;
				if (mrs_cnt_q == `LLDC_MRS_RESET_COUNT - 2'h1) begin
					mode_q <= {2'h0, addr[7:0]};
					init_ref_q <= {BANKS{1'b0}};
				end
			end else if (mrs_cnt_q != `LLDC_MRS_RESET_COUNT) begin
				mrs_cnt_q <= 2'h0;
			end
			if (is_bank_refresh_cmd)
				init_ref_q[bank_addr] <= 1'b1;
			if (&init_ref_q)
				init_done <= 1'b1;
		end
	end

	// ----------------------------------------
	// Per-bank row cycle counters and the shared refresh row counter
	// ----------------------------------------
	reg [3:0] busy_cnt_q [0:BANKS-1];
	integer b;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (b = 0; b < BANKS; b = b + 1)
				busy_cnt_q[b] <= 4'h0;
			refresh_row <= {ROWW{1'b0}};
			bank_busy <= {BANKS{1'b0}};
		end else begin
			for (b = 0; b < BANKS; b = b + 1) begin
				if ((is_read | is_write | is_bank_refresh_cmd) && bank_addr == b)
					busy_cnt_q[b] <= rl;
				else if (busy_cnt_q[b] != 4'h0)
					busy_cnt_q[b] <= busy_cnt_q[b] - 4'h1;
				bank_busy[b] <= (busy_cnt_q[b] > 4'h1);
			end
			if (is_bank_refresh_cmd)
				refresh_row <= refresh_row + 1'b1;
		end
	end

	// ----------------------------------------
	// Link clock sampling
	// ----------------------------------------
	reg [2:0] dk_q;
	reg dk_m_q;
	wire dk_edge;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dk_m_q <= 1'b0;
			dk_q <= 3'h0;
		end else begin
			dk_m_q <= write_data_clock;
			dk_q <= {dk_q[1:0], dk_m_q};
		end
	end
	// Either edge of the sampled write data clock captures an element.
	assign dk_edge = dk_q[1] ^ dk_q[2];
	reg [DW-1:0] dq_m_q;
	reg [DW-1:0] dq_s_q;
	reg dm_m_q;
	reg dm_s_q;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_m_q <= {DW{1'b0}};
			dq_s_q <= {DW{1'b0}};
			dm_m_q <= 1'b0;
			dm_s_q <= 1'b0;
		end else begin
			dq_m_q <= dq_in;
			dq_s_q <= dq_m_q;
			dm_m_q <= write_mask;
			dm_s_q <= dm_m_q;
		end
	end

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	reg [3:0] wl_cnt_q;
	reg [AW-1:0] wr_addr_q;
	reg [BAW-1:0] wr_bank_q;
	reg [2:0] wr_left_q;
	reg wr_arm_q;
	wire mem_wr;
	wire wr_first;
	// The arming edge is itself the first element, so it is written too.
	assign wr_first = wr_arm_q && (wl_cnt_q == 4'h0) && dk_edge && dk_q[1] &&
		!is_write;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wl_cnt_q <= 4'h0;
			wr_addr_q <= {AW{1'b0}};
			wr_bank_q <= {BAW{1'b0}};
			wr_left_q <= 3'h0;
			wr_arm_q <= 1'b0;
		end else begin
			if (is_write) begin
				wr_addr_q <= addr;
				wr_bank_q <= bank_addr;
				wl_cnt_q <= wl;
				wr_arm_q <= 1'b1;
				wr_left_q <= 3'h0;
			end else if (wr_arm_q) begin
				if (wl_cnt_q != 4'h0)
					wl_cnt_q <= wl_cnt_q - 4'h1;
				else if (wr_first) begin
					wr_arm_q <= 1'b0;
					wr_left_q <= blen - 3'h1;
					wr_addr_q <= wr_addr_q + 1'b1;
				end
			end
			if (wr_left_q != 3'h0 && dk_edge && !is_write) begin
				wr_left_q <= wr_left_q - 3'h1;
				wr_addr_q <= wr_addr_q + 1'b1;
			end
		end
	end
	assign mem_wr = (wr_first || (wr_left_q != 3'h0)) && dk_edge &&
		!dm_s_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Reads travel down a delay line so that back-to-back commands keep
	// their own addresses; each leaves at the read latency tap.
	localparam DLN = 8;
	reg [DLN-1:0] dl_v_q;
	reg [BAW+AW-1:0] dl_a_q [0:DLN-1];
	wire [3:0] tap;
	wire start_v;
	wire [BAW+AW-1:0] start_a;
	reg nxt_v_q;
	reg [BAW+AW-1:0] nxt_a_q;
	wire load;
	wire [BAW+AW-1:0] load_a;
	reg [BAW+AW-1:0] rd_addr_q;
	reg [2:0] rd_left_q;
	wire [DW-1:0] mem_rd;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [DW-1:0] fifo_out_data;
	reg rd_fetch_q;
	wire fetch;
	wire out_take;
	integer k;
	assign tap = rl - 4'h2;
	assign start_v = dl_v_q[tap[2:0]];
	assign start_a = dl_a_q[tap[2:0]];
	assign load = (rd_left_q == 3'h0) && (nxt_v_q || start_v);
	assign load_a = nxt_v_q ? nxt_a_q : start_a;
	assign fetch = (rd_left_q != 3'h0) && fifo_in_ready;
	assign out_take = read_data_clock & read_valid_strobe;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dl_v_q <= {DLN{1'b0}};
			for (k = 0; k < DLN; k = k + 1)
				dl_a_q[k] <= {(BAW+AW){1'b0}};
			nxt_v_q <= 1'b0;
			nxt_a_q <= {(BAW+AW){1'b0}};
			rd_addr_q <= {(BAW+AW){1'b0}};
			rd_left_q <= 3'h0;
			rd_fetch_q <= 1'b0;
		end else begin
			rd_fetch_q <= fetch;
			dl_v_q <= {dl_v_q[DLN-2:0], is_read};
			dl_a_q[0] <= {bank_addr, addr};
			for (k = 1; k < DLN; k = k + 1)
				dl_a_q[k] <= dl_a_q[k-1];
			if (load) begin
				rd_left_q <= blen;
				rd_addr_q <= load_a;
			end else if (fetch) begin
				rd_left_q <= rd_left_q - 3'h1;
				rd_addr_q <= {rd_addr_q[BAW+AW-1:AW],
					rd_addr_q[AW-1:0] + 1'b1};
			end
			// A start that cannot load yet waits one slot; a third replaces it.
			if (start_v && !(load && !nxt_v_q)) begin
				nxt_v_q <= 1'b1;
				nxt_a_q <= start_a;
			end else if (load) begin
				nxt_v_q <= 1'b0;
			end
		end
	end

	// The bank address selects its own region of the array.
	lldc_mem #(.WIDTH(DW), .AW(BAW+AW)) u_mem (
		.sys_clk(sys_clk),
		.wr_en(mem_wr),
		.wr_addr({wr_bank_q, wr_addr_q}),
		.wr_data(dq_s_q),
		.rd_addr(rd_addr_q),
		.rd_data(mem_rd)
	);

	// Read elements queue here so back-to-back bursts run seamless.
	lldc_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(rd_fetch_q),
		.in_ready(fifo_in_ready),
		.in_data(mem_rd),
		.out_valid(fifo_out_valid),
		.out_ready(out_take),
		.out_data(fifo_out_data),
		.flush(is_read & read_valid_strobe & ~fifo_out_valid)
	);

	// ----------------------------------------
	// Output drive
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data_clock <= 1'b0;
			read_valid_strobe <= 1'b0;
			dq_out <= {DW{1'b0}};
			dq_oe <= 1'b0;
		end else begin
			// Free-running, one element per full period.
			read_data_clock <= ~read_data_clock;
			// Data waits for the strobe so it never leads it.
			if (fifo_out_valid && read_data_clock && read_valid_strobe) begin
				dq_out <= fifo_out_data;
				dq_oe <= 1'b1;
			end else if (!fifo_out_valid) begin
				dq_oe <= 1'b0;
			end
			if (is_read && read_valid_strobe && !fifo_out_valid)
				read_valid_strobe <= 1'b0;
			else if (fifo_out_valid && !read_data_clock)
				read_valid_strobe <= 1'b1;
			else if (!fifo_out_valid)
				read_valid_strobe <= 1'b0;
		end
	end
endmodule // lldc_device
`default_nettype wire

/* File: testbench/lldc_monitor.sv */
// Checker on the read data pins and status outputs of the DRAM device.
`timescale 1ns/10ps
`default_nettype none
`include "lldc_consts.vh"
module lldc_monitor #(
	parameter DW = 9,
	parameter BANKS = 8
) (
	// Clock, reset and command pins
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic ref_n,
	// Read side and status
	input wire logic [DW-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic read_data_clock,
	input wire logic read_valid_strobe,
	input wire logic init_done,
	input wire logic [BANKS-1:0] bank_busy
);
	wire logic is_rd = {cs_n, we_n, ref_n} == `LLDC_CMD_READ;
	wire logic is_ref = {cs_n, we_n, ref_n} == `LLDC_CMD_BANK_REFRESH_CMD;
	logic [3:0] since_rd_q;
	logic [3:0] since_rd_d;
	// Saturates so that a long idle stretch never wraps into the window.
	assign since_rd_d = is_rd ? 4'h0 :
		(since_rd_q == 4'hF ? 4'hF : since_rd_q + 4'h1);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_rd_q <= 4'hF;
		end else begin
			since_rd_q <= since_rd_d;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_clock_toggles:
	assert property ($past(rst_n) |-> read_data_clock != $past(read_data_clock))
		else $error("read data clock stalled");
	a_strobe_leads:
	assert property ($rose(read_valid_strobe) |-> read_data_clock
		##1 (dq_oe && !read_data_clock))
		else $error("strobe not half cycle ahead");
	a_data_stands:
	assert property (dq_oe && $past(dq_oe) && read_data_clock |-> $stable(dq_out))
		else $error("read data changed inside an element");
	a_strobe_drop:
	assert property ($fell(dq_oe) |-> !read_valid_strobe)
		else $error("strobe still high after burst");
	a_bus_release:
	assert property ($fell(read_valid_strobe) |-> ##[0:3] !dq_oe)
		else $error("data lines not released");
	a_read_latency:
	assert property ($rose(dq_oe) |-> since_rd_q >= 4'h3 && since_rd_q <= 4'hC)
		else $error("read data outside latency window");
	a_refresh_busy:
	assert property (is_ref |-> ##2 bank_busy != '0)
		else $error("refresh left all banks idle");
	a_init_order:
	assert property ($rose(init_done) |-> $past(is_ref) || $past(is_ref, 2))
		else $error("init done without refresh");
endmodule // lldc_monitor
bind lldc_device lldc_monitor #(.DW(DW), .BANKS(BANKS)) i_mon (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.we_n(we_n),
	.ref_n(ref_n),
	.dq_out(dq_out),
	.dq_oe(dq_oe),
	.read_data_clock(read_data_clock),
	.read_valid_strobe(read_valid_strobe),
	.init_done(init_done),
	.bank_busy(bank_busy)
);
`default_nettype wire

/* File: testbench/lldc_ctrl_model.sv */
// Memory controller model driving commands and write bursts.
`timescale 1ns/10ps
`default_nettype none
`include "lldc_consts.vh"
module lldc_ctrl_model #(
	parameter DW = 9,
	parameter WL = 5
) (
	// Clock
	input wire logic sys_clk,
	// Command pins
	output var logic cs_n,
	output var logic we_n,
	output var logic ref_n,
	output var logic [2:0] bank_addr,
	output var logic [7:0] addr,
	// Write data side
	output var logic write_data_clock,
	output var logic write_mask,
	output var logic [DW-1:0] dq_in
);
	initial begin
		{cs_n, we_n, ref_n} = 3'h7;
		bank_addr = 3'h0;
		addr = 8'h00;
		write_data_clock = 1'b0;
		write_mask = 1'b0;
		dq_in = '0;
	end
	task automatic cmd(input logic [2:0] code, input logic [2:0] b,
		input logic [7:0] a);
		@(posedge sys_clk);
		#1;
		{cs_n, we_n, ref_n} = code;
		bank_addr = b;
		addr = a;
	endtask
	// Address lines are scrambled while idle so stale values never help.
	task automatic nop(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			{cs_n, we_n, ref_n} = 3'h7;
			addr = ~addr;
			bank_addr = ~bank_addr;
		end
	endtask
	// The write clock runs only within the burst and rests low afterwards.
	task automatic wburst(input logic [2:0] b, input logic [7:0] a,
		input logic [3:0][DW-1:0] d, input logic [3:0] m);
		cmd(`LLDC_CMD_WRITE, b, a);
		nop(WL + 1);
		for (int i = 0; i < 4; i++) begin
			dq_in = d[i];
			write_mask = m[i];
			#40 write_data_clock = ~write_data_clock;
			#40;
		end
		dq_in = ~dq_in;
		write_mask = ~write_mask;
	endtask
endmodule // lldc_ctrl_model
`default_nettype wire

/* File: testbench/lldc_device_tb_top.sv */
// Self-checking bench for the DRAM device command and data protocol.
`timescale 1ns/10ps
`default_nettype none
`include "lldc_consts.vh"
module lldc_device_tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	wire logic cs_n, we_n, ref_n, write_data_clock, write_mask, dq_oe;
	wire logic read_data_clock, read_valid_strobe, init_done;
	wire logic [2:0] bank_addr;
	wire logic [7:0] addr, bank_busy;
	wire logic [8:0] dq_in, dq_out;
	wire logic [12:0] refresh_row;
	int fails = 0;
	int check_count = 0;
	logic [3:0][8:0] da = {9'h1A3, 9'h0F0, 9'h155, 9'h0AA};
	logic [3:0][8:0] db = {9'h011, 9'h1EE, 9'h102, 9'h0FD};
	logic [3:0][8:0] dc = {9'h133, 9'h0CC, 9'h1FF, 9'h001};
	logic [8:0] exp_q [$];
	always #5 sys_clk = ~sys_clk;
	lldc_device i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
		.we_n(we_n), .ref_n(ref_n), .bank_addr(bank_addr), .addr(addr),
		.write_data_clock(write_data_clock), .write_mask(write_mask),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.read_data_clock(read_data_clock),
		.read_valid_strobe(read_valid_strobe), .init_done(init_done),
		.refresh_row(refresh_row), .bank_busy(bank_busy));
	lldc_ctrl_model i_ctrl (.sys_clk(sys_clk), .cs_n(cs_n), .we_n(we_n),
		.ref_n(ref_n), .bank_addr(bank_addr), .addr(addr),
		.write_data_clock(write_data_clock), .write_mask(write_mask),
		.dq_in(dq_in));
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("fails %0d check_count %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Samples one element per read clock period from the first driven one.
	task automatic rd_stream();
		int t;
		t = 0;
		while (dq_oe !== 1'b1 && t < 40) begin
			@(posedge sys_clk);
			#2;
			t++;
		end
		foreach (exp_q[i]) begin
			check("dq_oe", 16'h1, dq_oe);
			check("dq_out", exp_q[i], dq_out);
			repeat (2) @(posedge sys_clk);
			#2;
		end
		repeat (3) @(posedge sys_clk);
		#2;
		check("dq_oe idle", 16'h0, dq_oe);
		check("strobe idle", 16'h0, read_valid_strobe);
		exp_q.delete();
	endtask
	task automatic init_seq();
		i_ctrl.nop(20000);
		repeat (2) i_ctrl.cmd(`LLDC_CMD_MRS, 3'h0, 8'h00);
		i_ctrl.cmd(`LLDC_CMD_MRS, 3'h0, 8'h88);
		i_ctrl.nop(16);
		for (int b = 0; b < 8; b++) begin
			check("init_done", 16'h0, init_done);
			i_ctrl.cmd(`LLDC_CMD_BANK_REFRESH_CMD, b[2:0], 8'h5A);
			i_ctrl.nop(1);
		end
		i_ctrl.nop(1024);
		check("init_done", 16'h1, init_done);
	endtask
	task automatic write_read();
		i_ctrl.wburst(3'h1, 8'h10, da, 4'h0);
		i_ctrl.wburst(3'h2, 8'h10, db, 4'h0);
		i_ctrl.wburst(3'h1, 8'h10, dc, 4'h4);
		i_ctrl.nop(6);
		i_ctrl.cmd(`LLDC_CMD_READ, 3'h1, 8'h10);
		i_ctrl.cmd(`LLDC_CMD_READ, 3'h2, 8'h10);
		i_ctrl.nop(1);
		for (int i = 0; i < 4; i++)
			exp_q.push_back(i == 2 ? da[i] : dc[i]);
		for (int i = 0; i < 4; i++)
			exp_q.push_back(db[i]);
		rd_stream();
	endtask
	// Shorter latency and burst of two, reading back the earlier burst.
	task automatic burst_two();
		i_ctrl.cmd(`LLDC_CMD_MRS, 3'h0, 8'h83);
		i_ctrl.nop(16);
		i_ctrl.cmd(`LLDC_CMD_READ, 3'h1, 8'h10);
		i_ctrl.nop(1);
		exp_q.push_back(dc[0]);
		exp_q.push_back(dc[1]);
		rd_stream();
		i_ctrl.wburst(3'h3, 8'h20, da, 4'h0);
		i_ctrl.nop(4);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		check("dq_oe reset", 16'h0, dq_oe);
		rst_n = 1'b1;
		init_seq();
		write_read();
		burst_two();
		give_verdict();
	end
	initial begin
		#600000;
		fails++;
		give_verdict();
	end
endmodule // lldc_device_tb_top
`default_nettype wire
